// file: tlc_pkg.sv
package tlc_pkg;
    // core clock rate and derived timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned NS_PER_S        = 1_000_000_000;
    localparam int unsigned CLK_NS          = NS_PER_S / CLK_HZ;
    // nibble clock toward the mac: 2.5 MHz
    localparam int unsigned NIB_HZ          = 2_500_000;
    localparam int unsigned NIB_HALF_CYC    = CLK_HZ / NIB_HZ / 2;
    // bit time 100 ns, lock needs three bit times
    localparam int unsigned BIT_NS          = 100;
    localparam int unsigned LOCK_BITS       = 3;
    localparam int unsigned LOCK_CYC        = (LOCK_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
    // link pulse period 16 ms
    localparam int unsigned NLP_MS          = 16;
    localparam int unsigned NLP_CYC         = NLP_MS * (CLK_HZ / 1000);
    // link loss timeout, window 81 to 83 ms; 82 ms chosen inside it
    localparam int unsigned LOSS_MIN_MS     = 81;
    localparam int unsigned LOSS_MAX_MS     = 83;
    localparam int unsigned LOSS_MS         = (LOSS_MIN_MS + LOSS_MAX_MS) / 2;
    localparam int unsigned LOSS_CYC        = LOSS_MS * (CLK_HZ / 1000);
    // link pulses needed: more than seven
    localparam int unsigned NLP_VALID_MIN   = 7;
    // jabber and heartbeat defaults, overridable
    localparam int unsigned JAB_LIMIT_MS    = 20;
    localparam int unsigned JAB_LIMIT_CYC   = JAB_LIMIT_MS * (CLK_HZ / 1000);
    localparam int unsigned JAB_UNJAB_MS    = 500;
    localparam int unsigned JAB_UNJAB_CYC   = JAB_UNJAB_MS * (CLK_HZ / 1000);
    localparam int unsigned HB_NS           = 1000;
    localparam int unsigned HB_CYC          = HB_NS / CLK_NS;
    // control reset values
    localparam logic        SQUELCH_INH_RST = 1'h0;
    localparam logic        JABBER_INH_RST  = 1'h0;
    localparam logic        SQE_INH_RST     = 1'h0;
    // link monitor states
    typedef enum logic [1:0] {
        TLC_LNK_DOWN,
        TLC_LNK_PEND,
        TLC_LNK_UP
    } tlc_link_t;
endpackage : tlc_pkg

// file: tlc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter that pulses once when it expires; restart reloads it
module tlc_timer #(
    parameter int unsigned COUNT = 16
) (
    input  wire logic mclk,     // core clock
    input  wire logic resetn,   // async reset, active low
    input  wire logic restart,  // reload to COUNT; counting still needs run
    input  wire logic run,      // count enable
    output logic      expired   // one-cycle pulse at end
);
    localparam int unsigned W = $clog2(COUNT + 1);
    initial
    begin
        if (COUNT < 1) $error("tlc_timer count must be at least one");
    end
    logic [W-1:0] cnt_reg;
    wire          at_end = (cnt_reg == W'(1));
    // count down, stop at zero
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end
        else
        begin
            expired <= run && !restart && at_end;
            if (restart)
                cnt_reg <= W'(COUNT);
            else if (run && cnt_reg != '0)
                cnt_reg <= cnt_reg - W'(1);
        end
    end
endmodule : tlc_timer
`default_nettype wire

// file: tlc_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - drive a 2.5 MHz nibble clock toward the mac
// - acquire receive clock at preamble, track it while reception lasts
// - send one link pulse every 16 ms while the mac is idle
// - keep link pulses during reception; they never raise collision
// - link status latches low until read; one only while link valid
// - squelch off: more than seven pulses or any valid data validates
// - squelch on: more than seven pulses or valid data ending with idle
// - valid link stays valid while pulses or qualifying data arrive
// - no activity for 81 to 83 ms drops link and clears status
// - data valid only after lock held three bit times
// - data on invalid link validates only after packet ends
// - up transition alone does not set latched status
// - squelch inhibit resets to zero; one disables smart squelch
// - append idle marker after each transmitted packet
// - carrier sense: half duplex node tx or rx, else rx only
// - collision: half duplex rx during tx; full duplex only jabber or heartbeat
// - jabber: raise collision, block data, send pulses, set sticky flag
// - jabber inhibit resets to zero; one disables jabber detection
// - heartbeat collision pulse after tx enable falls
// - heartbeat only node, half duplex, link valid, inhibit clear
module tlc_link_ctrl #(
    parameter int unsigned JAB_LIMIT = tlc_pkg::JAB_LIMIT_CYC,   // jabber limit, cycles
    parameter int unsigned JAB_UNJAB = tlc_pkg::JAB_UNJAB_CYC,   // unjab interval, cycles
    parameter int unsigned HB_LEN    = tlc_pkg::HB_CYC,          // heartbeat length, cycles
    parameter int unsigned NLP_PER   = tlc_pkg::NLP_CYC,         // link pulse period
    parameter int unsigned LOSS_TO   = tlc_pkg::LOSS_CYC         // link loss timeout
) (
    input  wire logic mclk,            // core clock 100 MHz
    input  wire logic resetn,          // async reset, active low
    input  wire logic tx_en,           // mac transmit enable
    input  wire logic rx_activity,     // receiver sees carrier (pin)
    input  wire logic rx_lock,         // receive pll lock (pin)
    input  wire logic rx_nlp,          // link pulse detected (pin)
    input  wire logic rx_idl,          // valid end idle detected (pin)
    input  wire logic full_duplex,     // duplex select
    input  wire logic repeater_mode,   // repeater instead of node
    input  wire logic squelch_inh,     // smart squelch inhibit
    input  wire logic jabber_inh,      // jabber detection inhibit
    input  wire logic sqe_inh,         // heartbeat inhibit
    input  wire logic status_rd,       // management read strobe
    output logic      nib_clk,         // 2.5 MHz nibble clock
    output logic      rx_clk_track,    // receive clock being tracked
    output logic      crs,             // carrier sense
    output logic      col,             // collision
    output logic      tx_gate,         // transmit data reaches line
    output logic      tx_idl,          // end idle marker pulse
    output logic      tx_nlp,          // link pulse on line
    output logic      link_valid,      // live link state
    output logic      link_stat,       // latch-low link status
    output logic      jabber_det       // latch-high jabber flag
);
    initial
    begin
        if (JAB_LIMIT < 2 || JAB_UNJAB < 2 || HB_LEN < 1 || NLP_PER < 2 || LOSS_TO < 2)
            $error("tlc_link_ctrl timing parameters too small");
    end

    // two-flop synchronisers for pin inputs
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
        end
        else
        begin
            pin_s1_reg <= {rx_activity, rx_lock, rx_nlp, rx_idl};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    wire rx_act_s  = pin_s2_reg[3];
    wire rx_lock_s = pin_s2_reg[2];
    wire rx_nlp_s  = pin_s2_reg[1];
    wire rx_idl_s  = pin_s2_reg[0];

    // nibble clock divider
    localparam int unsigned NW = $clog2(tlc_pkg::NIB_HALF_CYC + 1);
    logic [NW-1:0] nib_cnt_reg;
    wire           nib_wrap = (nib_cnt_reg == NW'(tlc_pkg::NIB_HALF_CYC - 1));
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            nib_cnt_reg <= '0;
            nib_clk     <= 1'b0;
        end
        else
        begin
            nib_cnt_reg <= nib_wrap ? '0 : nib_cnt_reg + NW'(1);
            if (nib_wrap)
                nib_clk <= ~nib_clk;
        end
    end

    // receive clock tracking and lock qualification
    localparam int unsigned LW = $clog2(tlc_pkg::LOCK_CYC + 1);
    logic [LW-1:0] lock_cnt_reg;
    logic          data_ok_reg;        // lock held three bit times this packet
    logic          rx_prev_reg;
    logic          idl_seen_reg;
    wire           lock_done = (lock_cnt_reg == LW'(tlc_pkg::LOCK_CYC));
    wire           pkt_end   = rx_prev_reg && !rx_act_s;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lock_cnt_reg <= '0;
            data_ok_reg  <= 1'b0;
            rx_prev_reg  <= 1'b0;
            idl_seen_reg <= 1'b0;
            rx_clk_track <= 1'b0;
        end
        else
        begin
            rx_prev_reg  <= rx_act_s;
            rx_clk_track <= rx_act_s;
            if (!rx_act_s || !rx_lock_s)
                lock_cnt_reg <= '0;
            else if (!lock_done)
                lock_cnt_reg <= lock_cnt_reg + LW'(1);
            if (!rx_act_s && !pkt_end)
                data_ok_reg <= 1'b0;
            else if (lock_done)
                data_ok_reg <= 1'b1;
            if (!rx_act_s && !pkt_end)
                idl_seen_reg <= 1'b0;
            else if (rx_idl_s)
                idl_seen_reg <= 1'b1;
        end
    end

    // qualifying data event, taken at the end of the packet
    wire data_evt = pkt_end && (data_ok_reg || lock_done)
                    && (squelch_inh || idl_seen_reg || rx_idl_s);

    // link monitor state machine
    tlc_pkg::tlc_link_t lnk_reg;
    tlc_pkg::tlc_link_t lnk_next;
    logic [3:0]         nlp_cnt_reg;
    wire                loss_exp;
    wire                nlp_enough = (nlp_cnt_reg > 4'(tlc_pkg::NLP_VALID_MIN));
    always_comb
    begin
        lnk_next = lnk_reg;
        unique case (lnk_reg)
            tlc_pkg::TLC_LNK_DOWN:
            begin
                if (nlp_enough)
                    lnk_next = tlc_pkg::TLC_LNK_UP;
                else if (rx_act_s)
                    lnk_next = tlc_pkg::TLC_LNK_PEND;
            end
            tlc_pkg::TLC_LNK_PEND:
            begin
                if (data_evt || nlp_enough)
                    lnk_next = tlc_pkg::TLC_LNK_UP;
                else if (pkt_end)
                    lnk_next = tlc_pkg::TLC_LNK_DOWN;
            end
            tlc_pkg::TLC_LNK_UP:
            begin
                if (loss_exp)
                    lnk_next = tlc_pkg::TLC_LNK_DOWN;
            end
        endcase
    end
    wire link_up_n = (lnk_next == tlc_pkg::TLC_LNK_UP);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lnk_reg     <= tlc_pkg::TLC_LNK_DOWN;
            nlp_cnt_reg <= 4'h0;
            link_valid  <= 1'b0;
        end
        else
        begin
            lnk_reg    <= lnk_next;
            link_valid <= link_up_n;
            if (lnk_next == tlc_pkg::TLC_LNK_UP || loss_exp)
                nlp_cnt_reg <= 4'h0;
            else if (rx_nlp_s && !nlp_enough)
                nlp_cnt_reg <= nlp_cnt_reg + 4'h1;
        end
    end

    // link loss timer, restarted by any pulse, qualifying data or receive activity
    wire keep_alive = rx_nlp_s || data_evt || rx_act_s;
    wire loss_run   = (lnk_reg == tlc_pkg::TLC_LNK_UP);
    tlc_timer #(.COUNT(LOSS_TO)) u_loss (
        .mclk    (mclk),
        .resetn  (resetn),
        .restart (keep_alive || !loss_run),
        .run     (loss_run),
        .expired (loss_exp)
    );

    // jabber: transmit time limit, then unjab interval
    logic  jab_active_reg;
    logic  tx_prev_reg;
    wire   jab_trip;
    wire   unjab_done;
    wire   jab_on    = !jabber_inh;
    tlc_timer #(.COUNT(JAB_LIMIT)) u_jab (
        .mclk    (mclk),
        .resetn  (resetn),
        .restart (!tx_en || jab_active_reg),
        .run     (jab_on),
        .expired (jab_trip)
    );
    tlc_timer #(.COUNT(JAB_UNJAB)) u_unjab (
        .mclk    (mclk),
        .resetn  (resetn),
        .restart (jab_trip),
        .run     (jab_active_reg),
        .expired (unjab_done)
    );

    // heartbeat after transmit enable falls
    localparam int unsigned HW = $clog2(HB_LEN + 1);
    logic [HW-1:0] hb_cnt_reg;
    wire           tx_fall = tx_prev_reg && !tx_en;
    wire           hb_ok   = !repeater_mode && !full_duplex && link_valid && !sqe_inh;
    wire           hb_on   = (hb_cnt_reg != '0);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_prev_reg    <= 1'b0;
            jab_active_reg <= 1'b0;
            hb_cnt_reg     <= '0;
            tx_idl         <= 1'b0;
        end
        else
        begin
            tx_prev_reg <= tx_en;
            tx_idl      <= tx_fall;
            if (jab_trip)
                jab_active_reg <= 1'b1;
            else if (unjab_done || jabber_inh)
                jab_active_reg <= 1'b0;
            if (tx_fall && hb_ok)
                hb_cnt_reg <= HW'(HB_LEN);
            else if (hb_on)
                hb_cnt_reg <= hb_cnt_reg - HW'(1);
        end
    end

    // link pulse generator: idle or jabbering; reception does not stop it
    // the reload cycle is part of the period, and the timer rests at zero until first armed
    logic nlp_arm_reg; // low only in the first cycle after reset
    wire nlp_tick;
    wire tx_data  = tx_en && !jab_active_reg;
    tlc_timer #(.COUNT(NLP_PER - 1)) u_nlp (
        .mclk    (mclk),
        .resetn  (resetn),
        .restart (tx_data || nlp_tick || !nlp_arm_reg),
        .run     (!tx_data),
        .expired (nlp_tick)
    );

    // mac-facing carrier and collision
    wire crs_next = full_duplex || repeater_mode ? rx_act_s : (rx_act_s || tx_en);
    wire col_next = jab_active_reg || hb_on
                    || (!full_duplex && tx_data && rx_act_s);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            crs     <= 1'b0;
            col     <= 1'b0;
            tx_gate <= 1'b0;
            tx_nlp  <= 1'b0;
            nlp_arm_reg <= 1'b0;
        end
        else
        begin
            nlp_arm_reg <= 1'b1;
            crs     <= crs_next;
            col     <= col_next;
            tx_gate <= tx_data;
            tx_nlp  <= nlp_tick;
        end
    end

    // latching flags: read returns value, then reload from live state
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            link_stat  <= 1'b0;
            jabber_det <= 1'b0;
        end
        else
        begin
            if (!link_up_n)
                link_stat <= 1'b0;
            else if (status_rd)
                link_stat <= 1'b1;
            if (jab_trip || jab_active_reg)
                jabber_det <= 1'b1;
            else if (status_rd)
                jabber_det <= 1'b0;
        end
    end

    // helper: cycles for which the nibble clock has held its level
    logic          nib_seen_reg;
    logic [NW-1:0] nib_hold_reg;
    wire           nib_flip = (nib_clk != nib_seen_reg);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            nib_seen_reg <= 1'b0;
            nib_hold_reg <= '0;
        end
        else
        begin
            nib_seen_reg <= nib_clk;
            nib_hold_reg <= nib_flip ? NW'(1) : nib_hold_reg + NW'(1);
        end
    end

    // checks
    chk_col_fd_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        full_duplex && $stable(full_duplex) && !jab_active_reg && !hb_on |=> !col)
        else $error("collision raised in full duplex");
    chk_crs_half_tx: assert property (@(posedge mclk) disable iff (!resetn)
        !full_duplex && !repeater_mode && tx_en |=> crs)
        else $error("carrier sense missing during transmit");
    chk_loss_drop: assert property (@(posedge mclk) disable iff (!resetn)
        loss_exp |=> !link_valid && !link_stat)
        else $error("link not dropped on timeout");
    chk_stat_latch: assert property (@(posedge mclk) disable iff (!resetn)
        !link_stat && !status_rd |=> !link_stat)
        else $error("link status rose without read");
    chk_jab_block: assert property (@(posedge mclk) disable iff (!resetn)
        jab_trip |=> jab_active_reg ##1 (!tx_gate && col && jabber_det))
        else $error("jabber did not block and flag");
    chk_hb_start: assert property (@(posedge mclk) disable iff (!resetn)
        tx_fall && hb_ok |=> hb_on ##1 col)
        else $error("heartbeat missing");
    chk_hb_blocked: assert property (@(posedge mclk) disable iff (!resetn)
        tx_fall && !hb_ok && !hb_on |=> !hb_on)
        else $error("heartbeat ran while disabled");
    chk_nib_period: assert property (@(posedge mclk) disable iff (!resetn)
        nib_hold_reg <= NW'(tlc_pkg::NIB_HALF_CYC)
        && (nib_flip == (nib_hold_reg == NW'(tlc_pkg::NIB_HALF_CYC))))
        else $error("nibble clock period wrong");
    chk_pend_wait: assert property (@(posedge mclk) disable iff (!resetn)
        lnk_reg == tlc_pkg::TLC_LNK_PEND && rx_act_s && !nlp_enough |=> !link_valid)
        else $error("link validated mid packet");
    chk_tx_idl: assert property (@(posedge mclk) disable iff (!resetn)
        tx_fall |=> tx_idl)
        else $error("end idle marker missing");
    cov_link_up: cover property (@(posedge mclk) disable iff (!resetn) $rose(link_valid));
    cov_jabber: cover property (@(posedge mclk) disable iff (!resetn) jab_trip);
    cov_heartbeat: cover property (@(posedge mclk) disable iff (!resetn) $rose(hb_on));
    cov_collision: cover property (@(posedge mclk) disable iff (!resetn) tx_data && rx_act_s);
endmodule : tlc_link_ctrl
`default_nettype wire

// file: tlc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// remote link partner as the receiver sees it
module tlc_far_end (
    input  wire logic mclk,        // core clock
    output logic      rx_activity, // carrier present
    output logic      rx_lock,     // pll lock
    output logic      rx_nlp,      // link pulse seen
    output logic      rx_idl       // end idle seen
);
    // quiet line: receiver lines rest low without carrier
    initial
    begin
        rx_activity = 1'h0;
        rx_lock     = 1'h0;
        rx_nlp      = 1'h0;
        rx_idl      = 1'h0;
    end
    // move just after an edge, as the pulse and packet drivers do
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // carrier only, no lock: never counts as data
    task automatic set_carrier(input logic v);
        rx_activity = v;
    endtask : set_carrier
    // one link pulse then a gap; pulses are idle signalling
    task automatic send_nlp(input int gap);
        rx_nlp = 1'h1;
        tick(1);
        rx_nlp = 1'h0;
        tick(gap);
    endtask : send_nlp
    // packet: lock after two cycles, optional end idle in last carrier cycle
    task automatic send_packet(input int lock_cyc, input logic idle);
        rx_activity = 1'h1;
        tick(2);
        rx_lock = 1'h1;
        tick(lock_cyc);
        rx_lock = 1'h0;
        rx_idl  = idle;
        tick(1);
        rx_idl      = 1'h0;
        rx_activity = 1'h0;
    endtask : send_packet
endmodule : tlc_far_end
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the link control block
module tb_top;
    localparam int unsigned NLP_P = 100;
    localparam int unsigned LOSS  = 400;
    localparam int unsigned JAB_L = 50;
    localparam int unsigned JAB_U = 50;
    localparam int unsigned HB    = 10;
    localparam int unsigned CEIL  = 20000;
    logic mclk, resetn, tx_en, full_duplex, repeater_mode;
    logic squelch_inh, jabber_inh, sqe_inh, status_rd;
    logic rx_activity, rx_lock, rx_nlp, rx_idl;
    logic nib_clk, rx_clk_track, crs, col, tx_gate, tx_idl, tx_nlp;
    logic link_valid, link_stat, jabber_det;
    logic [31:0] seed;
    logic [3:0]  pick;
    int          err_count, n_checks, cyc, n, m;

    tlc_far_end far (.mclk(mclk), .rx_activity(rx_activity), .rx_lock(rx_lock),
        .rx_nlp(rx_nlp), .rx_idl(rx_idl));
    tlc_link_ctrl #(.JAB_LIMIT(JAB_L), .JAB_UNJAB(JAB_U), .HB_LEN(HB),
        .NLP_PER(NLP_P), .LOSS_TO(LOSS)) uut (
        .mclk(mclk), .resetn(resetn), .tx_en(tx_en), .rx_activity(rx_activity),
        .rx_lock(rx_lock), .rx_nlp(rx_nlp), .rx_idl(rx_idl),
        .full_duplex(full_duplex), .repeater_mode(repeater_mode),
        .squelch_inh(squelch_inh), .jabber_inh(jabber_inh), .sqe_inh(sqe_inh),
        .status_rd(status_rd), .nib_clk(nib_clk), .rx_clk_track(rx_clk_track),
        .crs(crs), .col(col), .tx_gate(tx_gate), .tx_idl(tx_idl), .tx_nlp(tx_nlp),
        .link_valid(link_valid), .link_stat(link_stat), .jabber_det(jabber_det));

    // 100 MHz clock
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == CEIL)
        begin
            err_count++;
            summarize();
        end
    end
    // xorshift source of stimulus
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xs = v ^ (v << 5);
    endfunction : xs
    // expected carrier sense and collision from duplex, mode, tx and rx
    function automatic logic exp_crs(input logic fd, input logic rep, input logic tx,
                                     input logic rx);
        exp_crs = rx | (tx & ~fd & ~rep);
    endfunction : exp_crs
    function automatic logic exp_col(input logic fd, input logic tx, input logic rx);
        exp_col = ~fd & tx & rx;
    endfunction : exp_col
    // step just after a clock edge
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // cycles until the next outgoing link pulse
    task automatic wait_nlp(output int k);
        k = 0;
        while (tx_nlp !== 1'h1 && k < 300)
        begin
            step(1);
            k++;
        end
    endtask : wait_nlp
    // one management read strobe
    task automatic rd();
        status_rd = 1'h1;
        step(1);
        status_rd = 1'h0;
        step(2);
    endtask : rd
    // a short frame, then count collision and idle-marker cycles after it
    task automatic frame(output int ncol, output int nidl);
        tx_en = 1'h1;
        step(10);
        tx_en = 1'h0;
        ncol = 0;
        nidl = 0;
        repeat (30)
        begin
            step(1);
            ncol += (col === 1'h1);
            nidl += (tx_idl === 1'h1);
        end
    endtask : frame
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // main sequence
    initial
    begin
        {tx_en, full_duplex, repeater_mode, jabber_inh, sqe_inh, status_rd} = 6'h00;
        squelch_inh = tlc_pkg::SQUELCH_INH_RST;
        resetn = 1'h0;
        seed = 32'hD0BF;
        step(20);
        check("link_stat_rst", link_stat, 1'h0);
        resetn = 1'h1;
        // nibble clock halves
        while (nib_clk !== 1'h0 && n < 100) step(1);
        while (nib_clk !== 1'h1 && m < 100) begin step(1); m++; end
        n = 0;
        while (nib_clk === 1'h1 && n < 100) begin step(1); n++; end
        check("nib_high", n, tlc_pkg::NIB_HALF_CYC);
        n = 0;
        while (nib_clk === 1'h0 && n < 100) begin step(1); n++; end
        check("nib_low", n, tlc_pkg::NIB_HALF_CYC);
        // idle link pulse period
        wait_nlp(n);
        step(1);
        wait_nlp(n);
        check("nlp_period", n + 1, NLP_P);
        // pulses continue during reception without collision
        far.set_carrier(1'h1);
        step(4);
        check("rx_track", rx_clk_track, 1'h1);
        step(1);
        wait_nlp(n);
        check("nlp_in_rx", tx_nlp, 1'h1);
        check("col_in_rx", col, 1'h0);
        far.set_carrier(1'h0);
        step(6);
        check("rx_untrack", rx_clk_track, 1'h0);
        // carrier and collision over every combination, then random ones
        jabber_inh = 1'h1;
        for (int i = 0; i < 40; i++)
        begin
            seed = xs(seed);
            pick = (i < 16) ? i[3:0] : seed[3:0];
            full_duplex = pick[0];
            repeater_mode = pick[1];
            tx_en = pick[2];
            far.set_carrier(pick[3]);
            step(6);
            check("crs", crs, exp_crs(pick[0], pick[1], pick[2], pick[3]));
            check("col", col, exp_col(pick[0], pick[2], pick[3]));
        end
        {tx_en, full_duplex, repeater_mode, jabber_inh} = 4'h0;
        far.set_carrier(1'h0);
        step(10);
        check("no_lock_down", link_valid, 1'h0);
        // short lock is not data; data without idle fails under squelch
        squelch_inh = 1'h1;
        far.send_packet(20, 1'h0);
        step(8);
        check("short_lock", link_valid, 1'h0);
        squelch_inh = tlc_pkg::SQUELCH_INH_RST;
        far.send_packet(40, 1'h0);
        step(8);
        check("sq_no_idle", link_valid, 1'h0);
        far.send_packet(40, 1'h1);
        check("defer_up", link_valid, 1'h0);
        step(8);
        check("sq_idle_up", link_valid, 1'h1);
        check("stat_no_set", link_stat, 1'h0);
        rd();
        check("stat_rd_up", link_stat, 1'h1);
        // pulses keep the link alive beyond the loss time, silence drops it
        repeat (6) far.send_nlp(NLP_P - 1);
        check("kept_up", link_valid, 1'h1);
        step(LOSS + 40);
        check("loss_down", link_valid, 1'h0);
        check("loss_stat", link_stat, 1'h0);
        // squelch off: any data validates
        squelch_inh = 1'h1;
        far.send_packet(40, 1'h0);
        step(8);
        check("nosq_up", link_valid, 1'h1);
        squelch_inh = 1'h0;
        step(LOSS + 40);
        // seven pulses are not enough, the eighth is
        repeat (7) far.send_nlp(20);
        check("nlp7", link_valid, 1'h0);
        far.send_nlp(8);
        check("nlp8", link_valid, 1'h1);
        rd();
        // heartbeat and end idle marker after a frame
        frame(n, m);
        check("hb_len", n, HB);
        check("idl_once", m, 1);
        for (int i = 0; i < 3; i++)
        begin
            far.send_nlp(2);
            {sqe_inh, repeater_mode, full_duplex} = 3'h1 << i;
            frame(n, m);
            check("hb_off", n, 0);
        end
        {sqe_inh, repeater_mode, full_duplex} = 3'h0;
        far.send_nlp(2);
        // jabber inhibited, then active
        jabber_inh = 1'h1;
        tx_en = 1'h1;
        step(JAB_L + 30);
        check("jinh_gate", tx_gate, 1'h1);
        check("jinh_flag", jabber_det, 1'h0);
        tx_en = 1'h0;
        step(40);
        jabber_inh = 1'h0;
        tx_en = 1'h1;
        step(JAB_L + 10);
        check("jab_col", col, 1'h1);
        check("jab_gate", tx_gate, 1'h0);
        check("jab_flag", jabber_det, 1'h1);
        tx_en = 1'h0;
        step(JAB_U + 40);
        check("jab_held", jabber_det, 1'h1);
        rd();
        check("jab_clear", jabber_det, 1'h0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
